// *** src/mv_select.v ***
// Contract
// - add setpoint offset to program setpoint
// - elapsed timer runs in manual, errors
// - area 1 stops program, outputs off
// - clamp computed value between limits
// - fixed values bypass the limit clamp
// - manual limit enable clamps manual value
// - one limit pair for heat/cool signed
// - reset value needs fixed enable
// - positive heats, negative cools
// - fixed values default zero
// - floating fixed is open, close, hold
// - direct setting gives target valve opening
// - fixed value ranges by control type
// - priority manual, reset, then error
// - reset value pot error map
// - error value pot error map
// - error on main, remote, pot close
// - open is out 1, close out 2
`timescale 1ns/10ps
`default_nettype none
`include "mv_select_regs.vh"
module mv_select
#(
   parameter integer PERIOD = `PERIOD_CYCLES
)
(
   // clock and reset
   input  wire        mclk,
   input  wire        reset,
   // avalon-mm slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   output wire [1:0]  response,
   // process inputs
   input  wire [15:0] program_setpoint,
   input  wire [15:0] computed_mv,
   input  wire [15:0] valve_position,
   input  wire        main_input_error,
   input  wire        remote_setpoint_input_error,
   input  wire        pot_input_error,
   // process outputs
   output reg  [15:0] control_setpoint,
   output reg  [15:0] heat_mv,
   output reg  [15:0] cool_mv,
   output reg         open_out,
   output reg         close_out,
   output reg         run_out,
   output reg  [31:0] elapsed_periods
);

   // ************************************************
   // register file
   // ************************************************
   reg [`CTRL_WIDTH-1:0] ctrl_q;
   reg [15:0]            program_setpoint_offset_q;
   reg [15:0]            output_upper_limit_q;
   reg [15:0]            output_lower_limit_q;
   reg [15:0]            manual_value_q;
   reg [15:0]            reset_value_q;
   reg [15:0]            fault_output_value_q;
   reg                   ack_q;
   reg [2:0]             source_q;
   // status word: drive state and the source picked at the last period
   wire [31:0]           status_word = {27'h0000000, close_out, open_out,
                                        source_q};

   // one wait state: accept on second cycle of a request
   assign waitrequest = (read | write) & ~ack_q;
   assign response    = 2'h0;

   wire hc = ctrl_q[`CTRL_HEAT_COOL];
   wire [15:0] wmin = hc ? `MV_HC_MIN : `MV_STD_MIN;

   // range check on fixed values
   function [15:0] fit;
      input [15:0] v;
      input [15:0] lo;
      begin
         if ($signed(v) < $signed(lo))
            fit = lo;
         else if ($signed(v) > $signed(`MV_STD_MAX))
            fit = `MV_STD_MAX;
         else
            fit = v;
      end
   endfunction

   // clamp to a window
   function [15:0] clamp;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if ($signed(v) > $signed(hi))
            clamp = hi;
         else if ($signed(v) < $signed(lo))
            clamp = lo;
         else
            clamp = v;
      end
   endfunction

   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ack_q                     <= 1'b0;
         ctrl_q                    <= {`CTRL_WIDTH{1'b0}};
         program_setpoint_offset_q <= `MV_ZERO;
         output_upper_limit_q      <= `MV_UPPER_RESET;
         output_lower_limit_q      <= `MV_LOWER_RESET;
         manual_value_q            <= `MV_ZERO;
         reset_value_q             <= `MV_ZERO;
         fault_output_value_q      <= `MV_ZERO;
         readdata                  <= 32'h00000000;
      end
      else
      begin
         ack_q <= (read | write) & ~ack_q;
         // writes land on the accepting edge, when waitrequest is low
         if (write & ack_q)
         begin
            case (address)
               `REG_CTRL:
                  ctrl_q <= writedata[`CTRL_WIDTH-1:0];
               `REG_SP_OFFSET:
                  program_setpoint_offset_q <= writedata[15:0];
               `REG_UPPER_LIMIT:
                  output_upper_limit_q <= writedata[15:0];
               `REG_LOWER_LIMIT:
                  output_lower_limit_q <= writedata[15:0];
               `REG_MANUAL_VALUE:
                  manual_value_q <= writedata[15:0];
               `REG_RESET_VALUE:
                  reset_value_q <= fit(writedata[15:0], wmin);
               `REG_FAULT_VALUE:
                  fault_output_value_q <= fit(writedata[15:0], wmin);
               default:
                  ;
            endcase
         end
         // read data loads on the first edge so it stands when accepted
         if (read & ~ack_q)
         begin
            case (address)
               `REG_CTRL:
                  readdata <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
               `REG_SP_OFFSET:
                  readdata <= {16'h0000, program_setpoint_offset_q};
               `REG_UPPER_LIMIT:
                  readdata <= {16'h0000, output_upper_limit_q};
               `REG_LOWER_LIMIT:
                  readdata <= {16'h0000, output_lower_limit_q};
               `REG_MANUAL_VALUE:
                  readdata <= {16'h0000, manual_value_q};
               `REG_RESET_VALUE:
                  readdata <= {16'h0000, reset_value_q};
               `REG_FAULT_VALUE:
                  readdata <= {16'h0000, fault_output_value_q};
               `REG_STATUS:
                  readdata <= status_word;
               default:
                  readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ************************************************
   // value selection
   // ************************************************
   // source codes, also shown in the status register
   localparam [2:0] SRC_AUTO   = 3'h0;
   localparam [2:0] SRC_MANUAL = 3'h1;
   localparam [2:0] SRC_RESET  = 3'h2;
   localparam [2:0] SRC_FAULT  = 3'h3;
   localparam [2:0] SRC_AREA1  = 3'h4;

   wire area1    = ctrl_q[`CTRL_AREA1];
   wire running  = ctrl_q[`CTRL_RUN] & ~area1;
   wire fixed_en = ctrl_q[`CTRL_FIXED_EN];
   wire pos_prop = ctrl_q[`CTRL_POS_PROP];
   wire closectl = ctrl_q[`CTRL_CLOSE_CTL];
   wire direct   = ctrl_q[`CTRL_DIRECT_POS] & closectl & pos_prop;
   // pot error only counts in close control
   wire fault = main_input_error | remote_setpoint_input_error
              | (pot_input_error & closectl & pos_prop);

   // ************************************************
   // selection conditions, highest priority first
   // ************************************************
   wire want_manual = ctrl_q[`CTRL_MANUAL];
   wire want_reset  = ~ctrl_q[`CTRL_RUN] & fixed_en;
   wire want_fault  = fault & fixed_en;

   reg [2:0]  src;
   reg [15:0] sel_mv;
   always @*
   begin
      src    = SRC_AUTO;
      sel_mv = clamp(computed_mv, output_lower_limit_q,
                     output_upper_limit_q);
      if (area1)
      begin
         src    = SRC_AREA1;
         sel_mv = `MV_ZERO;
      end
      else if (want_manual)
      begin
         src    = SRC_MANUAL;
         sel_mv = ctrl_q[`CTRL_MAN_LIMIT] ?
                  clamp(manual_value_q, output_lower_limit_q,
                        output_upper_limit_q) : manual_value_q;
      end
      else if (want_reset)
      begin
         src    = SRC_RESET;
         sel_mv = reset_value_q;
      end
      else if (want_fault)
      begin
         src    = SRC_FAULT;
         sel_mv = fault_output_value_q;
      end
   end

   wire fixed_src = (src == SRC_RESET) | (src == SRC_FAULT);
   // floating choice code lives in the low bits of the fixed value
   wire [1:0] choice = sel_mv[1:0];

   // ************************************************
   // control period and outputs
   // ************************************************
   reg [31:0] tick_q;
   // period strobe; every drive below except run_out and the area 1 clear of elapsed_periods moves only on this pulse
   wire       tick = (tick_q == PERIOD - 1);

   always @(posedge mclk or posedge reset)
   begin
      if (reset)
         tick_q <= 32'h00000000;
      else if (tick)
         tick_q <= 32'h00000000;
      else
         tick_q <= tick_q + 32'h00000001;
   end

   // ************************************************
   // next drive values
   // ************************************************
   reg [15:0] heat_d;
   reg [15:0] cool_d;
   reg        open_d;
   reg        close_d;
   // full travel and end-stop tests for a valve with no feedback, target tests against valve_position
   wire at_full   = $signed(sel_mv) >= $signed(`MV_FULL);
   wire at_shut   = $signed(sel_mv) <= $signed(`MV_ZERO);
   wire below_tgt = $signed(sel_mv) > $signed(valve_position);
   wire above_tgt = $signed(sel_mv) < $signed(valve_position);

   always @*
   begin
      heat_d  = 16'h0000;
      cool_d  = 16'h0000;
      open_d  = 1'b0;
      close_d = 1'b0;
      if (src == SRC_AREA1)
      begin
         // area 1 keeps every drive off
         heat_d = 16'h0000;
      end
      else if (!pos_prop)
      begin
         if ($signed(sel_mv) > $signed(`MV_ZERO))
            heat_d = sel_mv;
         else if (hc && $signed(sel_mv) < $signed(`MV_ZERO))
            cool_d = -sel_mv;
      end
      else if (fixed_src && !direct)
      begin
         open_d  = (choice == `CHOICE_OPEN);
         close_d = (choice == `CHOICE_CLOSE);
      end
      else if (fixed_src && pot_input_error)
      begin
         // no position feedback, so only full travel is possible
         open_d  = at_full;
         close_d = at_shut;
      end
      else
      begin
         // drive toward target opening; equal means rest
         open_d  = below_tgt;
         close_d = above_tgt;
      end
   end

   // ************************************************
   // output registers
   // ************************************************
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         source_q         <= SRC_AUTO;
         control_setpoint <= 16'h0000;
      end
      else if (tick)
      begin
         source_q         <= src;
         control_setpoint <= program_setpoint
                           + program_setpoint_offset_q;
      end
   end

   // drives change together so heat and cool never overlap
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         heat_mv   <= 16'h0000;
         cool_mv   <= 16'h0000;
         open_out  <= 1'b0;
         close_out <= 1'b0;
      end
      else if (tick)
      begin
         heat_mv   <= heat_d;
         cool_mv   <= cool_d;
         open_out  <= open_d;
         close_out <= close_d;
      end
   end

   // ************************************************
   // run output and elapsed time
   // ************************************************
   // the timer keeps counting through manual mode and input errors
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         run_out         <= 1'b0;
         elapsed_periods <= 32'h00000000;
      end
      else
      begin
         run_out <= running;
         if (area1)
            elapsed_periods <= 32'h00000000;
         else if (tick && running)
            elapsed_periods <= elapsed_periods + 32'h00000001;
      end
   end

endmodule
`default_nettype wire

// *** src/mv_select_regs.vh ***
`ifndef MV_SELECT_REGS_VH
`define MV_SELECT_REGS_VH
// register word offsets (byte address = 4 * index)
`define REG_CTRL          4'h0
`define REG_SP_OFFSET     4'h1
`define REG_UPPER_LIMIT   4'h2
`define REG_LOWER_LIMIT   4'h3
`define REG_MANUAL_VALUE  4'h4
`define REG_RESET_VALUE   4'h5
`define REG_FAULT_VALUE   4'h6
`define REG_STATUS        4'h7
// control register fields
`define CTRL_MANUAL       0
`define CTRL_RUN          1
`define CTRL_FIXED_EN     2
`define CTRL_MAN_LIMIT    3
`define CTRL_HEAT_COOL    4
`define CTRL_POS_PROP     5
`define CTRL_CLOSE_CTL    6
`define CTRL_DIRECT_POS   7
`define CTRL_AREA1        8
`define CTRL_WIDTH        9
// values in tenths of a percent, 16-bit signed
`define MV_ZERO           16'sh0000
`define MV_FULL           16'sh03e8
`define MV_UPPER_RESET    16'sh03e8
`define MV_LOWER_RESET    16'sh0000
`define MV_STD_MIN        16'shffce
`define MV_STD_MAX        16'sh041a
`define MV_HC_MIN         16'shfbe6
// position-proportional choices
`define CHOICE_HOLD       2'h0
`define CHOICE_OPEN       2'h1
`define CHOICE_CLOSE      2'h2
// control period: 100 us at 100 MHz
`define PERIOD_NS         100000
`define CLK_NS            10
`define PERIOD_CYCLES     (`PERIOD_NS / `CLK_NS)
`endif

// *** sim/mv_select_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module mv_select_chk
#(
   parameter integer PERIOD = 8
)
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic [15:0] heat_mv,
   input wire logic [15:0] cool_mv,
   input wire logic        open_out,
   input wire logic        close_out,
   input wire logic [31:0] elapsed_periods
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_WAIT_FIRST: assert property ($rose(read | write) |-> waitrequest)
      else $error("request accepted in its first cycle");
   AST_WAIT_NEXT: assert property ((read | write) && waitrequest
      |=> !waitrequest) else $error("request not answered in second cycle");
   AST_VALVE_ONE: assert property (!(open_out && close_out))
      else $error("open and close outputs both on");
   AST_HC_ONE: assert property (heat_mv == 16'h0000 || cool_mv == 16'h0000)
      else $error("heating and cooling driven together");
   AST_HEAT_MAX: assert property (heat_mv <= 16'h041a)
      else $error("heating value above full range");
   AST_ELAPSED_STEP: assert property ($changed(elapsed_periods) |->
      elapsed_periods == $past(elapsed_periods) + 32'h1
      || elapsed_periods == 32'h0) else $error("elapsed count jumped");
   AST_ELAPSED_HOLD: assert property ($changed(elapsed_periods)
      |=> $stable(elapsed_periods)[*6]) else $error("elapsed count too fast");
   AST_HEAT_HOLD: assert property ($changed(heat_mv)
      |=> $stable(heat_mv)[*6]) else $error("heating changed off period");
endmodule
`default_nettype wire

// *** sim/valve_actuator.sv ***
`timescale 1ns/10ps
`default_nettype none
module valve_actuator
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // motor drive
   input  wire logic        open_out,
   input  wire logic        close_out,
   // measured opening in tenths
   output logic [15:0]      valve_position
);
   // motor moves one tenth per clock and stops at its end stops
   always @(posedge mclk or posedge reset)
      if (reset)
         valve_position <= 16'h01f4;
      else if (open_out && valve_position < 16'h03e8)
         valve_position <= valve_position + 16'h0001;
      else if (close_out && valve_position != 16'h0000)
         valve_position <= valve_position - 16'h0001;
endmodule
`default_nettype wire

// *** sim/manipulated_value_selector_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mv_select_regs.vh"
module manipulated_value_selector_test;
   localparam integer PER = 8;
   logic               mclk, reset, read, write, main_e, rsp_e, pot_e;
   logic        [3:0]  address;
   logic        [1:0]  response;
   logic        [31:0] writedata, readdata, elapsed_periods, base, exp_q[$];
   logic        [15:0] program_setpoint, computed_mv, valve_position;
   logic        [15:0] control_setpoint, heat_mv, cool_mv;
   logic               waitrequest, open_out, close_out, run_out;
   logic signed [15:0] m, e;
   logic        [15:0] vtab[4] = '{16'h03e8, 16'hffce, 16'h01f4, 16'h0000};
   logic        [1:0]  otab[4] = '{2'h2, 2'h1, 2'h0, 2'h1};
   int                 kind_q[$], mismatches, num_checks, cycles, k;
   event               look_ev;
   mv_select #(.PERIOD(PER)) u_dut (.mclk, .reset, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .response, .program_setpoint,
      .computed_mv, .valve_position, .main_input_error(main_e),
      .remote_setpoint_input_error(rsp_e), .pot_input_error(pot_e),
      .control_setpoint, .heat_mv, .cool_mv, .open_out, .close_out,
      .run_out, .elapsed_periods);
   valve_actuator u_act (.mclk, .reset, .open_out, .close_out,
      .valve_position);
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // master holds the request until waitrequest is seen low
   task automatic bus(input logic rd, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      read <= rd;
      write <= !rd;
      address <= a;
      writedata <= d;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      kind_q.push_back(0);
      exp_q.push_back(x);
      bus(1'b1, a, 32'h0);
   endtask
   task automatic settle;
      repeat (PER + 2) @(posedge mclk);
   endtask
   // one look per negedge so no trigger is lost
   task automatic look(input int kd, input logic [31:0] x);
      @(negedge mclk);
      kind_q.push_back(kd);
      exp_q.push_back(x);
      -> look_ev;
   endtask
   function automatic logic [31:0] obs(input int kd);
      case (kd)
         1: obs = {16'h0000, heat_mv};
         2: obs = {16'h0000, cool_mv};
         3: obs = {30'h0, open_out, close_out};
         4: obs = {16'h0000, control_setpoint};
         5: obs = elapsed_periods - base;
         default: obs = {31'h0, run_out};
      endcase
   endfunction
   always @(posedge mclk)
      if (read === 1'b1 && waitrequest === 1'b0)
      begin
         void'(kind_q.pop_front());
         check(readdata, exp_q.pop_front());
         check({30'h0, response}, 32'h0);
      end
   always @(look_ev)
      check(obs(kind_q.pop_front()), exp_q.pop_front());
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         complete_run;
      end
   end
   initial
   begin
      {reset, read, write, main_e, rsp_e, pot_e} = 6'h20;
      {address, writedata, program_setpoint, computed_mv} = 0;
      base = 32'h0;
      k = $urandom(82);
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      rd(`REG_UPPER_LIMIT, 32'h3e8);
      rd(`REG_RESET_VALUE, 32'h0);
      rd(`REG_FAULT_VALUE, 32'h0);
      rd(4'h9, 32'h0);
      wr(`REG_RESET_VALUE, 32'h7d0);
      rd(`REG_RESET_VALUE, 32'h41a);
      wr(`REG_FAULT_VALUE, 32'hfc00);
      rd(`REG_FAULT_VALUE, 32'hffce);
      program_setpoint <= 16'($urandom_range(2000));
      wr(`REG_SP_OFFSET, 32'h64);
      settle;
      look(4, program_setpoint + 16'h0064);
      wr(`REG_UPPER_LIMIT, 32'h320);
      wr(`REG_LOWER_LIMIT, 32'hfed4);
      wr(`REG_CTRL, 32'h12);
      repeat (6)
      begin
         m = 16'($urandom_range(2100)) - 16'sd1050;
         computed_mv <= m;
         e = m > 800 ? 16'sd800 : m < -300 ? -16'sd300 : m;
         settle;
         look(1, e > 0 ? {16'h0, e} : 32'h0);
         look(2, e < 0 ? {16'h0, -e} : 32'h0);
      end
      wr(`REG_MANUAL_VALUE, 32'h3b6);
      main_e <= 1'b1;
      wr(`REG_CTRL, 32'h17);
      settle;
      look(1, 32'h3b6);
      wr(`REG_CTRL, 32'h1f);
      settle;
      look(1, 32'h320);
      wr(`REG_CTRL, 32'h15);
      settle;
      look(1, 32'h3b6);
      wr(`REG_CTRL, 32'h14);
      settle;
      look(1, 32'h41a);
      wr(`REG_CTRL, 32'h16);
      settle;
      look(2, 32'h32);
      main_e <= 1'b0;
      rsp_e <= 1'b1;
      pot_e <= 1'b1;
      wr(`REG_CTRL, 32'h17);
      @(negedge mclk);
      base = elapsed_periods;
      repeat (3 * PER - 1) @(negedge mclk);
      look(5, 32'h3);
      rsp_e <= 1'b0;
      pot_e <= 1'b0;
      wr(`REG_CTRL, 32'h24);
      for (k = 0; k < 3; k++)
      begin
         wr(`REG_RESET_VALUE, k);
         settle;
         look(3, k == 1 ? 32'h2 : k == 2 ? 32'h1 : 32'h0);
      end
      pot_e <= 1'b1;
      for (k = 0; k < 8; k++)
      begin
         wr(`REG_CTRL, k < 4 ? 32'he4 : 32'he6);
         wr(k < 4 ? `REG_RESET_VALUE : `REG_FAULT_VALUE, vtab[k % 4]);
         settle;
         look(3, otab[k % 4]);
      end
      pot_e <= 1'b0;
      wr(`REG_CTRL, 32'he4);
      wr(`REG_RESET_VALUE, 32'h3e8);
      settle;
      look(3, 32'h2);
      wr(`REG_CTRL, 32'h117);
      settle;
      base = 32'h0;
      look(1, 32'h0);
      look(6, 32'h0);
      look(5, 32'h0);
      complete_run;
   end
endmodule
bind mv_select mv_select_chk #(.PERIOD(PERIOD)) u_chk (.mclk, .reset,
   .read, .write, .waitrequest, .heat_mv, .cool_mv, .open_out,
   .close_out, .elapsed_periods);
`default_nettype wire
